// ==== hw/dprs_pkg.sv ====
package dprs_pkg;

  // ==========================================================
  // Command encodings and field positions
  // ==========================================================
  localparam int CA_W        = 10;
  localparam int BANKS       = 8;
  localparam int BANK_W      = 3;
  localparam int AP_BIT      = 0;   // Falling-edge CA0 carries the auto-precharge flag
  localparam int AB_BIT      = 4;   // Rising-edge CA4 selects all banks on precharge
  localparam int BA_LSB      = 7;   // Rising-edge CA7..CA9 bank address
  localparam int REF_SEL_BIT = 3;   // CA3 high selects all-bank refresh

  // ==========================================================
  // Timing defaults in clocks of the link
  // ==========================================================
  localparam int BL          = 8;
  localparam int WL_DEF      = 4;
  localparam int TWR_DEF     = 6;
  localparam int TRPPB_DEF   = 6;
  localparam int TRPAB_DEF   = 7;
  localparam int TRFCPB_DEF  = 30;
  localparam int TRFCAB_DEF  = 60;
  localparam int CNT_W       = 8;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [BANK_W-1:0] REF_BANK_RST = 3'h0;

  typedef enum logic [2:0] {
    DPRS_NOP, DPRS_ACT, DPRS_RD, DPRS_WR, DPRS_PRE, DPRS_PER_BANK_REFRESH, DPRS_ALL_BANK_REFRESH, DPRS_SREX
  } dprs_cmd_t;

  // Decoded command as captured on one rising link edge
  typedef struct packed {
    dprs_cmd_t         cmd;
    logic [BANK_W-1:0] bank;
    logic              allBanks;
    logic              autoPre;
  } dprs_req_t;

  // Per-bank status seen by the core side
  typedef struct packed {
    logic [BANKS-1:0] open;
    logic [BANKS-1:0] busy;
  } dprs_stat_t;

endpackage : dprs_pkg

// ==== hw/dprs_bank_timer.sv ====
`timescale 1ns/1ps
// One bank's open/precharge/refresh timing on the link clock
module dprs_bank_timer #(
  parameter int WL     = dprs_pkg::WL_DEF,
  parameter int TWR    = dprs_pkg::TWR_DEF,
  parameter int TRPPB  = dprs_pkg::TRPPB_DEF,
  parameter int TRPAB  = dprs_pkg::TRPAB_DEF,
  parameter int TRFCPB = dprs_pkg::TRFCPB_DEF,
  parameter int TRFCAB = dprs_pkg::TRFCAB_DEF
) (
  input  wire logic linkClk,     // Link clock
  input  wire logic linkNrst,    // Link-domain reset, active low
  input  wire logic actHit,      // Activate to this bank
  input  wire logic wrApHit,     // Write with auto-precharge to this bank
  input  wire logic rdApHit,     // Read with auto-precharge to this bank
  input  wire logic preHit,      // Precharge affecting this bank
  input  wire logic preAll,      // That precharge was all-bank
  input  wire logic refPbHit,    // Per-bank refresh of this bank
  input  wire logic refAbHit,    // All-bank refresh
  output logic      bankOpen,    // Row open
  output logic      bankBusy,    // Precharging or refreshing
  output logic      apStart      // Auto-precharge starts this edge
);

  logic [dprs_pkg::CNT_W-1:0] apCnt_reg;
  logic [dprs_pkg::CNT_W-1:0] busyCnt_reg;
  logic                       apPend_reg;
  logic                       open_reg;

  localparam logic [dprs_pkg::CNT_W-1:0] WR_AP_DLY = dprs_pkg::CNT_W'(WL + dprs_pkg::BL/2 + TWR);
  localparam logic [dprs_pkg::CNT_W-1:0] RD_AP_DLY = dprs_pkg::CNT_W'(dprs_pkg::BL/2);
  localparam int                         WR_AP_CYC = WL + dprs_pkg::BL/2 + TWR;

  wire apFire = apPend_reg && (apCnt_reg == dprs_pkg::CNT_W'(1));
  wire anyPre = preHit || apFire;

  assign apStart  = apFire;
  assign bankOpen = open_reg;
  assign bankBusy = (busyCnt_reg != '0);

  always_ff @(posedge linkClk or negedge linkNrst) begin
    if (!linkNrst) begin
      apPend_reg <= 1'b0;
      apCnt_reg  <= '0;
    end else if (wrApHit) begin
      apPend_reg <= 1'b1;
      apCnt_reg  <= WR_AP_DLY;
    end else if (rdApHit) begin
      apPend_reg <= 1'b1;
      apCnt_reg  <= RD_AP_DLY;
    end else if (apPend_reg) begin
      apPend_reg <= !apFire;
      apCnt_reg  <= apCnt_reg - dprs_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge linkClk or negedge linkNrst) begin
    if (!linkNrst) begin
      open_reg <= 1'b0;
    end else if (actHit) begin
      open_reg <= 1'b1;
    end else if (anyPre) begin
      open_reg <= 1'b0;
    end
  end

  always_ff @(posedge linkClk or negedge linkNrst) begin
    if (!linkNrst) begin
      busyCnt_reg <= '0;
    end else if (refAbHit) begin
      busyCnt_reg <= dprs_pkg::CNT_W'(TRFCAB);
    end else if (refPbHit) begin
      busyCnt_reg <= dprs_pkg::CNT_W'(TRFCPB);
    end else if (anyPre) begin
      busyCnt_reg <= dprs_pkg::CNT_W'(preAll && preHit ? TRPAB : TRPPB);
    end else if (busyCnt_reg != '0) begin
      busyCnt_reg <= busyCnt_reg - dprs_pkg::CNT_W'(1);
    end
  end

  a_wrap_delay: assert property (@(posedge linkClk) disable iff (!linkNrst)
    wrApHit && !rdApHit |-> ##WR_AP_CYC apStart)
    else $error("auto-precharge after write not at WL+BL/2+tWR");
  a_pre_closes: assert property (@(posedge linkClk) disable iff (!linkNrst)
    anyPre && !actHit |=> !bankOpen)
    else $error("bank stayed open after precharge");
  a_pb_busy: assert property (@(posedge linkClk) disable iff (!linkNrst)
    refPbHit && !refAbHit |=> bankBusy [*8])
    else $error("refreshed bank not busy during tRFCpb");

endmodule : dprs_bank_timer

// ==== hw/dprs_sched.sv ====
`timescale 1ns/1ps
// Contract
// - write auto-precharge starts tWR after burst
// - precharge period from latest bank precharge
// - bursts never truncated, seamless across banks
// - refresh decoded from CS and CA3
// - per-bank refresh bank counter round robin
// - counter cleared by reset, SR exit, all-bank
// - refreshed bank inaccessible during tRFCpb
// - no auto-precharge leaves bank open
module dprs_sched #(
  parameter int WL     = dprs_pkg::WL_DEF,
  parameter int TWR    = dprs_pkg::TWR_DEF,
  parameter int TRPPB  = dprs_pkg::TRPPB_DEF,
  parameter int TRPAB  = dprs_pkg::TRPAB_DEF,
  parameter int TRFCPB = dprs_pkg::TRFCPB_DEF,
  parameter int TRFCAB = dprs_pkg::TRFCAB_DEF
) (
  input  wire logic                        mclk,          // System clock, 50 MHz
  input  wire logic                        nrst,          // Async reset, active low
  input  wire logic                        linkClk,       // Controller-driven command clock
  input  wire logic                        csN,           // Chip select, active low
  input  wire logic [dprs_pkg::CA_W-1:0]   caRise,        // CA bus at rising edge
  input  wire logic [dprs_pkg::CA_W-1:0]   caFall,        // CA bus at falling edge
  input  wire logic                        selfRefExit,   // Self-refresh exit pulse, link side
  output logic [dprs_pkg::BANKS-1:0]       bankOpenSys,   // Open banks, system domain
  output logic [dprs_pkg::BANKS-1:0]       bankBusySys,   // Busy banks, system domain
  output logic [dprs_pkg::BANK_W-1:0]      refBankSys,    // Next per-bank refresh target
  output logic                             illegalSys,    // Illegal command seen, sticky
  output logic                             refEventSys    // One-cycle pulse per refresh
);

  // ==========================================================
  // Link-side reset and decode
  // ==========================================================
  logic                              linkRstA_reg;
  logic                              linkNrst;
  logic [dprs_pkg::BANK_W-1:0]       refBank_reg;
  logic [dprs_pkg::BANKS-1:0]        open;
  logic [dprs_pkg::BANKS-1:0]        busy;
  logic [dprs_pkg::BANKS-1:0]        apStart;
  logic                              illegal_reg;
  logic                              refTog_reg;
  dprs_pkg::dprs_req_t               req;

  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      linkRstA_reg <= 1'b0;
      linkNrst     <= 1'b0;
    end else begin
      linkRstA_reg <= 1'b1;
      linkNrst     <= linkRstA_reg;
    end
  end

  function automatic dprs_pkg::dprs_cmd_t decodeCmd(input logic cs_n,
                                                    input logic [dprs_pkg::CA_W-1:0] ca);
    if (cs_n)
      return dprs_pkg::DPRS_NOP;
    unique casez (ca[3:0])
      4'b??10: return dprs_pkg::DPRS_ACT;
      4'b?101: return dprs_pkg::DPRS_RD;
      4'b?001: return dprs_pkg::DPRS_WR;
      4'b1011: return dprs_pkg::DPRS_PRE;
      4'b0100: return dprs_pkg::DPRS_PER_BANK_REFRESH;
      4'b1100: return dprs_pkg::DPRS_ALL_BANK_REFRESH;
      default: return dprs_pkg::DPRS_NOP;
    endcase
  endfunction : decodeCmd

  wire dprs_pkg::dprs_cmd_t cmdNow = decodeCmd(csN, caRise);
  wire [dprs_pkg::BANK_W-1:0] caBank = caRise[dprs_pkg::BA_LSB +: dprs_pkg::BANK_W];

  assign req.cmd      = selfRefExit ? dprs_pkg::DPRS_SREX : cmdNow;
  assign req.bank     = (cmdNow == dprs_pkg::DPRS_PER_BANK_REFRESH) ? refBank_reg : caBank;
  assign req.allBanks = caRise[dprs_pkg::AB_BIT];
  assign req.autoPre  = caFall[dprs_pkg::AP_BIT];

  wire isAct   = (req.cmd == dprs_pkg::DPRS_ACT);
  wire isRd    = (req.cmd == dprs_pkg::DPRS_RD);
  wire isWr    = (req.cmd == dprs_pkg::DPRS_WR);
  wire isPre   = (req.cmd == dprs_pkg::DPRS_PRE);
  wire isRefPb = (req.cmd == dprs_pkg::DPRS_PER_BANK_REFRESH);
  wire isRefAb = (req.cmd == dprs_pkg::DPRS_ALL_BANK_REFRESH);
  wire isSrex  = (req.cmd == dprs_pkg::DPRS_SREX);

  wire [dprs_pkg::BANKS-1:0] bankSel = dprs_pkg::BANKS'(1) << req.bank;

  // ==========================================================
  // Bank timers
  // ==========================================================
  for (genvar b = 0; b < dprs_pkg::BANKS; b++) begin : g_bank
    dprs_bank_timer #(
      .WL     (WL),
      .TWR    (TWR),
      .TRPPB  (TRPPB),
      .TRPAB  (TRPAB),
      .TRFCPB (TRFCPB),
      .TRFCAB (TRFCAB)
    ) u_timer (
      .linkClk  (linkClk),
      .linkNrst (linkNrst),
      .actHit   (isAct && bankSel[b]),
      .wrApHit  (isWr && req.autoPre && bankSel[b]),
      .rdApHit  (isRd && req.autoPre && bankSel[b]),
      .preHit   (isPre && (req.allBanks || bankSel[b])),
      .preAll   (req.allBanks),
      .refPbHit (isRefPb && bankSel[b]),
      .refAbHit (isRefAb),
      .bankOpen (open[b]),
      .bankBusy (busy[b]),
      .apStart  (apStart[b])
    );
  end

  // ==========================================================
  // Per-bank refresh counter
  // ==========================================================
  always_ff @(posedge linkClk or negedge linkNrst) begin
    if (!linkNrst) begin
      refBank_reg <= dprs_pkg::REF_BANK_RST;
    // resync on all-bank refresh or SR exit
    end else if (isRefAb || isSrex) begin
      refBank_reg <= dprs_pkg::REF_BANK_RST;
    // advance round robin, wraps at 7
    end else if (isRefPb) begin
      refBank_reg <= refBank_reg + dprs_pkg::BANK_W'(1);
    end
  end

  // ==========================================================
  // Illegal access detection
  // ==========================================================
  // refresh of a non-idle bank flagged
  wire refBad = (isRefPb && |((open | busy) & bankSel)) || (isRefAb && |(open | busy));
  // access to a busy bank flagged
  wire accBad = (isAct || isRd || isWr) && |(busy & bankSel);

  always_ff @(posedge linkClk or negedge linkNrst) begin
    if (!linkNrst) begin
      illegal_reg <= 1'b0;
    end else if (refBad || accBad) begin
      illegal_reg <= 1'b1;
    end
  end

  always_ff @(posedge linkClk or negedge linkNrst) begin
    if (!linkNrst) begin
      refTog_reg <= 1'b0;
    end else if (isRefPb || isRefAb) begin
      refTog_reg <= !refTog_reg;
    end
  end

  a_ref_wrap: assert property (@(posedge linkClk) disable iff (!linkNrst)
    isRefPb && !isSrex && refBank_reg == 3'h7 |=> refBank_reg == 3'h0)
    else $error("refresh bank counter did not wrap");
  a_ref_step: assert property (@(posedge linkClk) disable iff (!linkNrst)
    isRefPb |=> refBank_reg == $past(refBank_reg) + 3'h1)
    else $error("refresh bank counter did not advance");
  a_all_bank_refresh_sync: assert property (@(posedge linkClk) disable iff (!linkNrst)
    isRefAb |=> refBank_reg == 3'h0)
    else $error("all-bank refresh did not clear counter");
  a_srex_sync: assert property (@(posedge linkClk) disable iff (!linkNrst)
    isSrex |=> refBank_reg == 3'h0)
    else $error("self-refresh exit did not clear counter");
  a_ab_busy: assert property (@(posedge linkClk) disable iff (!linkNrst)
    isRefAb |=> &busy)
    else $error("all-bank refresh did not busy all banks");
  a_ref_idle: assert property (@(posedge linkClk) disable iff (!linkNrst)
    isRefPb && (open[req.bank] || busy[req.bank]) |=> illegal_reg)
    else $error("refresh of non-idle bank not flagged");
  a_busy_access: assert property (@(posedge linkClk) disable iff (!linkNrst)
    isAct && busy[req.bank] |=> illegal_reg)
    else $error("access to busy bank not flagged");
  a_nap_open: assert property (@(posedge linkClk) disable iff (!linkNrst)
    (isRd || isWr) && !req.autoPre && open[req.bank] |-> ##1 !apStart[$past(req.bank)])
    else $error("plain burst started auto-precharge");

  c_per_bank_refresh: cover property (@(posedge linkClk) disable iff (!linkNrst) isRefPb ##1 isRefPb);
  c_wrap: cover property (@(posedge linkClk) disable iff (!linkNrst) isWr && req.autoPre);
  c_all_bank_refresh: cover property (@(posedge linkClk) disable iff (!linkNrst) isRefAb);
  c_apfire: cover property (@(posedge linkClk) disable iff (!linkNrst) |apStart);

  // ==========================================================
  // Crossing into system clock
  // ==========================================================
  logic [2*dprs_pkg::BANKS+1:0] syncA_reg;
  logic [2*dprs_pkg::BANKS+1:0] syncB_reg;
  logic [dprs_pkg::BANK_W-1:0]  bankA_reg;
  logic [dprs_pkg::BANK_W-1:0]  bankB_reg;
  logic                         togC_reg;

  // Status levels; refresh bank changes only on a refresh or SR exit and goes through its own two flops alongside the toggle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      syncA_reg   <= '0;
      syncB_reg   <= '0;
      bankA_reg   <= '0;
      bankB_reg   <= '0;
      togC_reg    <= 1'b0;
      bankOpenSys <= '0;
      bankBusySys <= '0;
      refBankSys  <= '0;
      illegalSys  <= 1'b0;
      refEventSys <= 1'b0;
    end else begin
      syncA_reg   <= {refTog_reg, illegal_reg, busy, open};
      syncB_reg   <= syncA_reg;
      bankA_reg   <= refBank_reg;
      bankB_reg   <= bankA_reg;
      togC_reg    <= syncB_reg[2*dprs_pkg::BANKS+1];
      bankOpenSys <= syncB_reg[dprs_pkg::BANKS-1:0];
      bankBusySys <= syncB_reg[2*dprs_pkg::BANKS-1:dprs_pkg::BANKS];
      illegalSys  <= syncB_reg[2*dprs_pkg::BANKS];
      refEventSys <= togC_reg ^ syncB_reg[2*dprs_pkg::BANKS+1];
      refBankSys  <= bankB_reg;
    end
  end

endmodule : dprs_sched

// ==== sim/dprs_ctrl_model.sv ====
`timescale 1ns/1ps
module dprs_ctrl_model (
  input  wire logic                      linkClk,     // Link clock
  output logic                           csN,         // Chip select, active low
  output logic [dprs_pkg::CA_W-1:0]      caRise,      // Rising-edge CA
  output logic [dprs_pkg::CA_W-1:0]      caFall,      // Falling-edge CA
  output logic                           selfRefExit  // Self-refresh exit pulse
);
  initial begin
    csN = 1'b1;
    caRise = 10'h155;
    caFall = 10'h2aa;
    selfRefExit = 1'b0;
  end

  // ==========================================================
  // Idle cycles: bus released, CA toggles so no stale value shows
  // ==========================================================
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge linkClk);
      csN <= 1'b1;
      caRise <= ~caRise;
      caFall <= ~caFall;
      selfRefExit <= 1'b0;
    end
  endtask : idle

  // ==========================================================
  // One command, then one idle cycle more than the gap asked for by the caller
  // ==========================================================
  // spacing kept
  task automatic issue(input logic [dprs_pkg::CA_W-1:0] rise,
                       input logic [dprs_pkg::CA_W-1:0] fall, input int gap);
    @(negedge linkClk);
    csN <= 1'b0;
    caRise <= rise;
    caFall <= fall;
    idle(gap + 1);
  endtask : issue

  task automatic srExit();
    @(negedge linkClk);
    selfRefExit <= 1'b1;
    idle(6);
  endtask : srExit
endmodule : dprs_ctrl_model

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
  localparam int K_ACT = 0;
  localparam int K_RD  = 1;
  localparam int K_WR  = 2;
  localparam int K_PRE = 3;
  localparam int K_REF = 4;
  logic                        mclk;
  logic                        nrst;
  logic                        linkClk;
  logic                        csN;
  logic [dprs_pkg::CA_W-1:0]   caRise;
  logic [dprs_pkg::CA_W-1:0]   caFall;
  logic                        selfRefExit;
  logic [dprs_pkg::BANKS-1:0]  bankOpenSys;
  logic [dprs_pkg::BANKS-1:0]  bankBusySys;
  logic [dprs_pkg::BANK_W-1:0] refBankSys;
  logic                        illegalSys;
  logic                        refEventSys;
  logic [31:0]                 rng;
  logic [2:0]                  refQ[$];
  int                          miscompares;
  int                          checksDone;

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #15 linkClk = ~linkClk;
  end

  dprs_sched #(.TWR(3), .TRPPB(3), .TRFCPB(8), .TRFCAB(12)) i_dut (
    .mclk(mclk), .nrst(nrst), .linkClk(linkClk), .csN(csN), .caRise(caRise),
    .caFall(caFall), .selfRefExit(selfRefExit), .bankOpenSys(bankOpenSys),
    .bankBusySys(bankBusySys), .refBankSys(refBankSys), .illegalSys(illegalSys),
    .refEventSys(refEventSys));
  dprs_ctrl_model i_ctrl (.linkClk(linkClk), .csN(csN), .caRise(caRise), .caFall(caFall),
    .selfRefExit(selfRefExit));

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [31:0] xrand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xrand

  task automatic cmpBits(input string what, input logic [7:0] exp, input logic [7:0] got);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmpBits

  task automatic acc(input int kind, input logic [2:0] bank, input logic flag, input int gap);
    logic [31:0] r;
    logic [9:0]  rise;
    r = xrand();
    case (kind)
      K_ACT: rise = {bank, r[4:0], 2'b10};
      K_RD: rise = {bank, r[1:0], 2'b00, 3'b101};
      K_WR: rise = {bank, r[1:0], 2'b00, 3'b001};
      K_PRE: rise = {bank, 1'b0, 1'b0, flag, 4'b1011};
      default: rise = {6'h00, flag, 3'b100};
    endcase
    i_ctrl.issue(rise, {r[14:6], flag}, gap);
  endtask : acc

  task automatic expectOut(input int sel, input logic [7:0] exp);
    logic [7:0] got;
    for (int i = 0; i < 200; i++) begin
      @(negedge mclk);
      got = (sel == 0) ? bankOpenSys : (sel == 1) ? bankBusySys :
            (sel == 2) ? {7'h00, illegalSys} : {5'h00, refBankSys};
      if (got === exp) break;
    end
    cmpBits((sel == 0) ? "open" : (sel == 1) ? "busy" : (sel == 2) ? "illegal" : "refBank",
            exp, got);
  endtask : expectOut

  task automatic finish_test();
    if (miscompares == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // ==========================================================
  // Watcher: each refresh event seen while the queue is not empty takes the oldest expected bank
  // ==========================================================
  initial begin
    forever begin
      @(negedge mclk);
      if (refEventSys === 1'b1 && refQ.size() > 0) begin
        repeat (4) @(negedge mclk);
        cmpBits("refBank", {5'h00, refQ.pop_front()}, {5'h00, refBankSys});
      end
    end
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    logic [31:0] r;
    logic [2:0]  b;
    nrst = 1'b0;
    rng = 32'h00000055;
    miscompares = 0;
    checksDone = 0;
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge linkClk);
    expectOut(3, 8'h00);
    expectOut(0, 8'h00);
    r = xrand();
    b = r[2:0];
    acc(K_ACT, b, 1'b0, 20);
    acc(K_RD, b, 1'b0, 20);
    acc(K_WR, b, 1'b0, 20);
    expectOut(0, 8'h01 << b);
    acc(K_WR, b, 1'b1, 0);
    repeat (6) @(negedge linkClk);
    cmpBits("open", 8'h01 << b, bankOpenSys);
    expectOut(1, 8'h01 << b);
    expectOut(0, 8'h00);
    expectOut(1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      acc(K_ACT, 3'(i), 1'b0, 2);
    end
    acc(K_WR, 3'h0, 1'b1, 3);
    acc(K_WR, 3'h1, 1'b1, 20);
    expectOut(0, 8'hfc);
    acc(K_PRE, 3'h3, 1'b0, 0);
    acc(K_PRE, 3'h0, 1'b1, 0);
    expectOut(1, 8'hff);
    expectOut(0, 8'h00);
    expectOut(1, 8'h00);
    for (int i = 0; i < 9; i++) begin
      refQ.push_back(3'(i + 1));
      acc(K_REF, 3'h0, 1'b0, 0);
      expectOut(1, 8'h01 << (i % 8));
      i_ctrl.idle(10);
    end
    expectOut(1, 8'h00);
    refQ.push_back(3'h2);
    acc(K_REF, 3'h0, 1'b0, 10);
    refQ.push_back(3'h0);
    acc(K_REF, 3'h0, 1'b1, 14);
    refQ.push_back(3'h1);
    acc(K_REF, 3'h0, 1'b0, 10);
    expectOut(3, 8'h01);
    i_ctrl.srExit();
    expectOut(3, 8'h00);
    expectOut(2, 8'h00);
    acc(K_ACT, 3'h0, 1'b0, 20);
    acc(K_REF, 3'h0, 1'b0, 10);
    expectOut(2, 8'h01);
    repeat (20) @(negedge mclk);
    cmpBits("pending", 8'h00, 8'(refQ.size()));
    finish_test();
  end
endmodule : tb
